// ---- common/lcr_pkg.sv ----
// Purpose: constants for the link command response builder
// Assumes: 32-bit classic wishbone register bus, 25 MHz clock
// Notes: payload words leave most significant byte first
//
// Functional notes
// RULE1: accept set-link command with good checksum and id; answer type 0x89.
// RULE2: set-link answer word: response code high half, reason code low half.
// RULE3: command-specific reason codes only when reporting of them is enabled.
// RULE4: reason 0x1 when host network driver is active.
// RULE5: reason 0x2 when requested setting conflicts with fiber media.
// RULE6: reason 0x3 when requested settings contradict, e.g. forced gigabit half.
// RULE7: reason 0x4 when request exceeds current low-power capability.
// RULE8: reason 0x5 when more than one speed is forced.
// RULE9: reason 0x6 when a phy access fails during set-link or link-status.
// RULE10: controller sends link-status query as type 0x0a without payload.
// RULE11: accept link-status query with good checksum and id; answer type 0x8a.
// RULE12: link-status answer: codes, status word, other, vendor status, in order.
// RULE13: status bit 0 shows link up.
// RULE14: speed-duplex field zero if negotiation incomplete, serdes, or no mode.
// RULE15: speed-duplex encodes modes 1 to 8; 9 to 0xf reserved.
// RULE16: without serdes the field may show the forced link setting.
// RULE17: bit 5 set when auto-negotiation is enabled.
// RULE18: bit 5 zero when auto-negotiation is unsupported.
// RULE19: bit 6 set once auto-negotiation has completed.
// RULE20: bit 6 zero if negotiation unsupported or disabled; includes parallel detect.
// RULE21: bit 7 set when link came from parallel detection, else clear.
// RULE22: response words serialized most significant byte first.
package lcr_pkg;
  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADR_CMD = 8'h00;
  localparam logic [7:0] ADR_SETTINGS = 8'h04;
  localparam logic [7:0] ADR_CTRL = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0c;
  localparam logic [7:0] ADR_RSP_CODES = 8'h10;
  localparam logic [7:0] ADR_LINK_STATUS = 8'h14;
  // ------------------------------------------------------------
  // command register fields
  // ------------------------------------------------------------
  localparam int CMD_CSUM_OK_BIT = 8;
  localparam int CMD_ID_OK_BIT = 9;
  localparam logic [7:0] CMD_SET_LINK = 8'h09;
  localparam logic [7:0] CMD_GET_LINK = 8'h0a;
  localparam logic [7:0] RSP_SET_LINK = 8'h89;
  localparam logic [7:0] RSP_GET_LINK = 8'h8a;
  // ------------------------------------------------------------
  // link settings word fields
  // ------------------------------------------------------------
  localparam int SET_AN_BIT = 0;
  localparam int SET_SPD_LSB = 1;
  localparam int SET_SPD_W = 4;
  localparam int SET_1G_BIT = 3;
  localparam int SET_10G_BIT = 4;
  localparam int SET_HALF_BIT = 8;
  localparam int SET_FULL_BIT = 9;
  // ------------------------------------------------------------
  // control and status fields
  // ------------------------------------------------------------
  localparam int CTRL_REASON_EN_BIT = 0;
  localparam int CTRL_FIBER_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DROP_BIT = 1;
  localparam int STAT_REFUSED_BIT = 2;
  localparam int STAT_TYPE_LSB = 8;
  // ------------------------------------------------------------
  // response and reason codes
  // ------------------------------------------------------------
  localparam logic [15:0] RC_OK = 16'h0000;
  localparam logic [15:0] RC_FAILED = 16'h0001;
  localparam logic [15:0] RS_NONE = 16'h0000;
  localparam logic [15:0] RS_HOST_DRV = 16'h0001;
  localparam logic [15:0] RS_MEDIA = 16'h0002;
  localparam logic [15:0] RS_PARAM = 16'h0003;
  localparam logic [15:0] RS_POWER = 16'h0004;
  localparam logic [15:0] RS_SPEED = 16'h0005;
  localparam logic [15:0] RS_PHY_ERR = 16'h0006;
  // ------------------------------------------------------------
  // link status word fields
  // ------------------------------------------------------------
  localparam int LS_LINK_BIT = 0;
  localparam int LS_SPD_LSB = 1;
  localparam int LS_AN_EN_BIT = 5;
  localparam int LS_AN_DONE_BIT = 6;
  localparam int LS_PDET_BIT = 7;
  localparam logic [3:0] SPD_NONE = 4'h0;
  localparam logic [3:0] SPD_MAX = 4'h8;
  // ------------------------------------------------------------
  // payload sizes in words minus one (bytes 16 up to checksum)
  // ------------------------------------------------------------
  localparam logic [1:0] WORDS_SET_LINK = 2'h0;
  localparam logic [1:0] WORDS_GET_LINK = 2'h3;
  localparam logic [1:0] BYTE_LAST = 2'h3;
  typedef enum logic [0:0] {
    LCR_IDLE = 1'b0,
    LCR_SEND = 1'b1
  } lcr_state_t;
endpackage

// ---- hw/lcr_top.sv ----
// Purpose: builds set-link and link-status response payloads
// Assumes: checksum and id checks are done upstream and flagged in the command write
// Notes: phy status pins are synchronised; payload streams out a byte at a time
`timescale 1ns/1ns
module lcr_top #(
  parameter bit AN_SUPPORTED = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_link_up,
  input wire logic i_an_enabled,
  input wire logic i_an_complete,
  input wire logic i_parallel_det,
  input wire logic i_serdes,
  input wire logic i_forced,
  input wire logic [3:0] i_forced_mode,
  input wire logic [3:0] i_highest_common_mode,
  input wire logic i_phy_err,
  input wire logic i_host_drv_active,
  input wire logic i_low_power,
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_byte,
  output logic o_rsp_last,
  output logic [7:0] o_rsp_type,
  input wire logic i_rsp_ready
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  localparam int PIN_W = 17;
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1_reg;
  logic [PIN_W-1:0] pin_s2_reg;
  logic [PIN_W-1:0] pin_s3_reg;
  logic [PIN_W-1:0] pin_reg;
  assign pin_raw = {i_link_up, i_an_enabled, i_an_complete, i_parallel_det, i_serdes,
    i_forced, i_forced_mode, i_highest_common_mode, i_phy_err, i_host_drv_active, i_low_power};
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end
  genvar g;
  generate
    for (g = 0; g < PIN_W; g = g + 1) begin : g_pin
      // a change counts once the last two stages agree
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          pin_reg[g] <= 1'b0;
        end else if (pin_s2_reg[g] == pin_s3_reg[g]) begin
          pin_reg[g] <= pin_s3_reg[g];
        end
      end
    end
  endgenerate
  logic s_link_up;
  logic s_an_en;
  logic s_an_done;
  logic s_pdet;
  logic s_serdes;
  logic s_forced;
  logic [3:0] s_forced_mode;
  logic [3:0] s_hcm;
  logic s_phy_err;
  logic s_host_drv;
  logic s_low_power;
  assign {s_link_up, s_an_en, s_an_done, s_pdet, s_serdes, s_forced, s_forced_mode,
    s_hcm, s_phy_err, s_host_drv, s_low_power} = pin_reg;

  // ------------------------------------------------------------
  // wishbone slave
  // ------------------------------------------------------------
  logic [31:0] settings_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] rsp_codes_reg;
  logic [31:0] link_status_reg;
  logic busy_reg;
  logic drop_reg;
  logic refused_reg;
  logic [7:0] last_type_reg;
  logic wb_req;
  logic wr_cmd;
  lcr_pkg::lcr_state_t state_reg;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return res;
  endfunction

  assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr_cmd = wb_req && i_wb_we && (i_wb_adr == lcr_pkg::ADR_CMD) && i_wb_sel[0];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= wb_req;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_wb_dat <= '0;
    end else if (wb_req && !i_wb_we) begin
      if (i_wb_adr == lcr_pkg::ADR_SETTINGS) begin
        o_wb_dat <= settings_reg;
      end else if (i_wb_adr == lcr_pkg::ADR_CTRL) begin
        o_wb_dat <= ctrl_reg;
      end else if (i_wb_adr == lcr_pkg::ADR_STATUS) begin
        o_wb_dat <= '0;
        o_wb_dat[lcr_pkg::STAT_BUSY_BIT] <= busy_reg;
        o_wb_dat[lcr_pkg::STAT_DROP_BIT] <= drop_reg;
        o_wb_dat[lcr_pkg::STAT_REFUSED_BIT] <= refused_reg;
        o_wb_dat[lcr_pkg::STAT_TYPE_LSB +: 8] <= last_type_reg;
      end else if (i_wb_adr == lcr_pkg::ADR_RSP_CODES) begin
        o_wb_dat <= rsp_codes_reg;
      end else if (i_wb_adr == lcr_pkg::ADR_LINK_STATUS) begin
        o_wb_dat <= link_status_reg;
      end else begin
        // command register and unmapped space read as zero
        o_wb_dat <= '0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      settings_reg <= '0;
    end else if (wb_req && i_wb_we && i_wb_adr == lcr_pkg::ADR_SETTINGS) begin
      settings_reg <= merge(settings_reg, i_wb_dat, i_wb_sel);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_reg <= lcr_pkg::CTRL_RESET;
    end else if (wb_req && i_wb_we && i_wb_adr == lcr_pkg::ADR_CTRL) begin
      ctrl_reg <= merge(ctrl_reg, i_wb_dat, i_wb_sel);
    end
  end

  // ------------------------------------------------------------
  // command acceptance
  // ------------------------------------------------------------
  logic [7:0] cmd_type;
  logic cmd_good;
  logic is_set;
  logic is_get;
  logic take_cmd;
  assign cmd_type = i_wb_dat[7:0];
  assign cmd_good = i_wb_sel[1] && i_wb_dat[lcr_pkg::CMD_CSUM_OK_BIT] && i_wb_dat[lcr_pkg::CMD_ID_OK_BIT];
  assign is_set = cmd_good && (cmd_type == lcr_pkg::CMD_SET_LINK); // RULE1
  assign is_get = cmd_good && (cmd_type == lcr_pkg::CMD_GET_LINK); // RULE10 RULE11
  assign take_cmd = wr_cmd && !busy_reg && (is_set || is_get);

  // sticky flags; a new event wins over a same-cycle clear
  logic clr_stat;
  assign clr_stat = wb_req && i_wb_we && i_wb_adr == lcr_pkg::ADR_STATUS && i_wb_sel[0];
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      drop_reg <= 1'b0;
    end else if (wr_cmd && !(is_set || is_get)) begin
      drop_reg <= 1'b1;
    end else if (clr_stat && i_wb_dat[lcr_pkg::STAT_DROP_BIT]) begin
      drop_reg <= 1'b0;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      refused_reg <= 1'b0;
    end else if (wr_cmd && busy_reg && (is_set || is_get)) begin
      refused_reg <= 1'b1;
    end else if (clr_stat && i_wb_dat[lcr_pkg::STAT_REFUSED_BIT]) begin
      refused_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // set-link reason code
  // ------------------------------------------------------------
  logic [3:0] spd_req;
  logic multi_spd;
  logic an_req;
  logic [15:0] set_reason;
  assign spd_req = settings_reg[lcr_pkg::SET_SPD_LSB +: lcr_pkg::SET_SPD_W];
  assign multi_spd = (spd_req & (spd_req - 4'h1)) != 4'h0;
  assign an_req = settings_reg[lcr_pkg::SET_AN_BIT];
  always_comb begin
    if (s_phy_err) begin
      set_reason = lcr_pkg::RS_PHY_ERR; // RULE9
    end else if (s_host_drv) begin
      set_reason = lcr_pkg::RS_HOST_DRV; // RULE4
    end else if (ctrl_reg[lcr_pkg::CTRL_FIBER_BIT] && !an_req && (spd_req != 4'h0)
                 && !settings_reg[lcr_pkg::SET_1G_BIT] && !settings_reg[lcr_pkg::SET_10G_BIT]) begin
      set_reason = lcr_pkg::RS_MEDIA; // RULE5
    end else if (!an_req && multi_spd) begin
      set_reason = lcr_pkg::RS_SPEED; // RULE8
    end else if (!ctrl_reg[lcr_pkg::CTRL_FIBER_BIT] && !an_req && settings_reg[lcr_pkg::SET_1G_BIT]
                 && settings_reg[lcr_pkg::SET_HALF_BIT] && !settings_reg[lcr_pkg::SET_FULL_BIT]) begin
      set_reason = lcr_pkg::RS_PARAM; // RULE6
    end else if (s_low_power && (settings_reg[lcr_pkg::SET_1G_BIT] || settings_reg[lcr_pkg::SET_10G_BIT])) begin
      set_reason = lcr_pkg::RS_POWER; // RULE7
    end else begin
      set_reason = lcr_pkg::RS_NONE;
    end
  end

  // ------------------------------------------------------------
  // link status word
  // ------------------------------------------------------------
  logic an_en_eff;
  logic an_done_eff;
  logic [3:0] spd_field;
  logic [31:0] ls_word;
  assign an_en_eff = AN_SUPPORTED && s_an_en; // RULE17 RULE18
  assign an_done_eff = an_en_eff && s_an_done; // RULE19 RULE20
  always_comb begin
    if (s_serdes) begin
      spd_field = lcr_pkg::SPD_NONE; // RULE14
    end else if (s_forced) begin
      spd_field = (s_forced_mode > lcr_pkg::SPD_MAX) ? lcr_pkg::SPD_NONE : s_forced_mode; // RULE16
    end else if (!an_done_eff || s_hcm > lcr_pkg::SPD_MAX) begin
      spd_field = lcr_pkg::SPD_NONE; // RULE14 RULE15
    end else begin
      spd_field = s_hcm; // RULE15
    end
  end
  always_comb begin
    ls_word = '0;
    ls_word[lcr_pkg::LS_LINK_BIT] = s_link_up; // RULE13
    ls_word[lcr_pkg::LS_SPD_LSB +: 4] = spd_field;
    ls_word[lcr_pkg::LS_AN_EN_BIT] = an_en_eff;
    ls_word[lcr_pkg::LS_AN_DONE_BIT] = an_done_eff;
    ls_word[lcr_pkg::LS_PDET_BIT] = an_done_eff && s_pdet; // RULE21
  end

  logic [15:0] reason_next;
  always_comb begin
    if (is_set) begin
      reason_next = set_reason;
    end else if (s_phy_err) begin
      reason_next = lcr_pkg::RS_PHY_ERR; // RULE9
    end else begin
      reason_next = lcr_pkg::RS_NONE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rsp_codes_reg <= '0;
      link_status_reg <= '0;
      last_type_reg <= '0;
    end else if (take_cmd) begin
      // code high half, reason low half
      rsp_codes_reg[31:16] <= (reason_next == lcr_pkg::RS_NONE) ? lcr_pkg::RC_OK : lcr_pkg::RC_FAILED; // RULE2
      rsp_codes_reg[15:0] <= ctrl_reg[lcr_pkg::CTRL_REASON_EN_BIT] ? reason_next : lcr_pkg::RS_NONE; // RULE3
      link_status_reg <= is_get ? ls_word : '0;
      last_type_reg <= is_set ? lcr_pkg::RSP_SET_LINK : lcr_pkg::RSP_GET_LINK; // RULE1 RULE11
    end
  end

  // ------------------------------------------------------------
  // payload serialiser
  // ------------------------------------------------------------
  logic [1:0] word_idx_reg;
  logic [1:0] byte_idx_reg;
  logic [1:0] words_last_reg;
  logic adv;
  logic [31:0] cur_word;
  assign adv = o_rsp_valid && i_rsp_ready;

  // other indications and vendor status words stay zero
  function automatic logic [31:0] pick_word(input logic [1:0] idx, input logic [31:0] w0,
                                            input logic [31:0] w1);
    if (idx == 2'h0) begin
      return w0;
    end else if (idx == 2'h1) begin
      return w1;
    end
    return '0;
  endfunction

  function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] b);
    return w[8*(3 - b) +: 8]; // RULE22
  endfunction

  assign cur_word = pick_word(word_idx_reg, rsp_codes_reg, link_status_reg); // RULE12
  // busy follows the state alone: folding take_cmd in would close a
  // combinational loop through the acceptance check, which already
  // refuses a command whenever a response is still streaming
  assign busy_reg = (state_reg == lcr_pkg::LCR_SEND);

  logic [1:0] nb;
  logic [1:0] nw;
  assign nb = byte_idx_reg + 2'h1;
  assign nw = word_idx_reg + 2'h1;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= lcr_pkg::LCR_IDLE;
      word_idx_reg <= '0;
      byte_idx_reg <= '0;
      words_last_reg <= '0;
      o_rsp_valid <= 1'b0;
      o_rsp_byte <= '0;
      o_rsp_last <= 1'b0;
      o_rsp_type <= '0;
    end else begin
      case (state_reg)
        lcr_pkg::LCR_IDLE: begin
          if (take_cmd) begin
            state_reg <= lcr_pkg::LCR_SEND;
            word_idx_reg <= '0;
            byte_idx_reg <= '0;
            words_last_reg <= is_set ? lcr_pkg::WORDS_SET_LINK : lcr_pkg::WORDS_GET_LINK;
            o_rsp_type <= is_set ? lcr_pkg::RSP_SET_LINK : lcr_pkg::RSP_GET_LINK;
          end
        end
        lcr_pkg::LCR_SEND: begin
          if (!o_rsp_valid) begin
            // codes are now stored; present the first byte
            o_rsp_valid <= 1'b1;
            o_rsp_byte <= pick_byte(cur_word, byte_idx_reg);
            o_rsp_last <= 1'b0;
          end else if (adv) begin
            if (o_rsp_last) begin
              o_rsp_valid <= 1'b0;
              o_rsp_last <= 1'b0;
              state_reg <= lcr_pkg::LCR_IDLE;
            end else begin
              if (byte_idx_reg == lcr_pkg::BYTE_LAST) begin
                word_idx_reg <= nw;
                byte_idx_reg <= '0;
                o_rsp_byte <= pick_byte(pick_word(nw, rsp_codes_reg, link_status_reg), 2'h0);
                o_rsp_last <= 1'b0;
              end else begin
                byte_idx_reg <= nb;
                o_rsp_byte <= pick_byte(cur_word, nb);
                o_rsp_last <= (nb == lcr_pkg::BYTE_LAST) && (word_idx_reg == words_last_reg);
              end
            end
          end
        end
        default: begin
          state_reg <= lcr_pkg::LCR_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- tb/lcr_sink.sv ----
// Purpose: management controller side, takes response bytes
// Assumes: prompt, or slow with ready every other cycle
// Notes: bytes shift in msb first
`timescale 1ns/1ns
module lcr_sink (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_clr,
  input wire logic i_slow,
  input wire logic i_valid,
  input wire logic [7:0] i_byte,
  output logic o_ready,
  output logic [127:0] o_data,
  output logic [4:0] o_count
);
  logic phase_reg;
  always_ff @(posedge i_clk) begin
    if (i_rst) phase_reg <= 1'b0;
    else phase_reg <= ~phase_reg;
  end
  assign o_ready = ~i_slow | phase_reg;
  always_ff @(posedge i_clk) begin
    if (i_rst || i_clr) begin
      o_data <= 128'h0;
      o_count <= 5'h0;
    end else if (i_valid && o_ready) begin
      o_data <= {o_data[119:0], i_byte};
      o_count <= o_count + 5'h1;
    end
  end
endmodule

// ---- tb/lcr_top_asserts.sv ----
// Purpose: port checker for lcr_top
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every lcr_top instance
`timescale 1ns/1ns
module lcr_top_asserts (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic o_wb_ack,
  input wire logic o_rsp_valid,
  input wire logic [7:0] o_rsp_byte,
  input wire logic o_rsp_last,
  input wire logic [7:0] o_rsp_type,
  input wire logic i_rsp_ready
);
  logic [4:0] cnt_reg;
  logic cmd_w;
  logic cmd_go;
  logic take;
  default clocking cb @(posedge i_clk); endclocking
  assign take = o_rsp_valid & i_rsp_ready;
  assign cmd_w = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack & (i_wb_adr == 8'h00) & (i_wb_sel[1:0] == 2'h3);
  assign cmd_go = cmd_w & (i_wb_dat[9:8] == 2'h3) & ((i_wb_dat[7:0] == 8'h09) | (i_wb_dat[7:0] == 8'h0a));
  // counts bytes taken within one response
  always_ff @(posedge i_clk) begin
    if (i_rst || !o_rsp_valid) cnt_reg <= 5'h0;
    else if (take) cnt_reg <= cnt_reg + 5'h1;
  end
  ack_pulse_a: assert property (disable iff (i_rst) o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
  ack_time_a: assert property (disable iff (i_rst) i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack not one cycle after request");
  rsp_start_a: assert property (disable iff (i_rst) cmd_go && !o_rsp_valid |=> !o_rsp_valid ##1 o_rsp_valid)
    else $error("response stream did not start");
  bad_drop_a: assert property (disable iff (i_rst) cmd_w && i_wb_dat[9:8] != 2'h3 && !o_rsp_valid |=>
    !o_rsp_valid [*4]) else $error("stream after bad command");
  rsp_type_a: assert property (disable iff (i_rst) $rose(o_rsp_valid) |-> o_rsp_type == 8'h89 || o_rsp_type == 8'h8a)
    else $error("bad response type");
  byte_hold_a: assert property (disable iff (i_rst) o_rsp_valid && !i_rsp_ready |=>
    o_rsp_valid && $stable(o_rsp_byte) && $stable(o_rsp_last)) else $error("byte changed while stalled");
  rsp_len_a: assert property (disable iff (i_rst) take && o_rsp_last |-> cnt_reg == (o_rsp_type == 8'h89 ? 5'd3 : 5'd15))
    else $error("wrong response length");
  last_end_a: assert property (disable iff (i_rst) take && o_rsp_last |=> !o_rsp_valid)
    else $error("valid stayed after last byte");
  code_high_a: assert property (disable iff (i_rst) o_rsp_valid && cnt_reg == 5'h0 |-> o_rsp_byte == 8'h00)
    else $error("response code high byte not zero");
  type_stable_a: assert property (disable iff (i_rst) o_rsp_valid && $past(o_rsp_valid) |-> $stable(o_rsp_type))
    else $error("type changed in response");
  reset_out_a: assert property (i_rst |=> !o_rsp_valid && !o_wb_ack) else $error("outputs active after reset");
  set_cov: cover property (disable iff (i_rst) take && o_rsp_last && o_rsp_type == 8'h89);
  get_cov: cover property (disable iff (i_rst) take && o_rsp_last && o_rsp_type == 8'h8a);
  stall_cov: cover property (disable iff (i_rst) o_rsp_valid && !i_rsp_ready);
endmodule
bind lcr_top lcr_top_asserts i_lcr_top_asserts (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_ack(o_wb_ack), .o_rsp_valid(o_rsp_valid), .o_rsp_byte(o_rsp_byte), .o_rsp_last(o_rsp_last),
  .o_rsp_type(o_rsp_type), .i_rsp_ready(i_rsp_ready));

// ---- tb/tb_lcr_top.sv ----
// Purpose: self-checking bench for lcr_top
// Assumes: 25 MHz clock, wishbone classic master
// Notes: pins held 12 clocks before each command
`timescale 1ns/1ns
module tb_lcr_top;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic cyc = 1'b0, we = 1'b0, clr = 1'b0, slow = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, q, rd;
  logic [16:0] pv = 17'h0;
  logic ack, valid, last, ready;
  logic [7:0] rbyte, rtype;
  logic [127:0] sdat;
  logic [4:0] scnt;
  int num_errors = 0;
  int n_compared = 0;
  always #20 i_clk = ~i_clk;
  lcr_top i_lcr_top (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(dat), .o_wb_dat(q), .o_wb_ack(ack), .i_link_up(pv[0]),
    .i_an_enabled(pv[1]), .i_an_complete(pv[2]), .i_parallel_det(pv[3]), .i_serdes(pv[4]),
    .i_forced(pv[5]), .i_forced_mode(pv[9:6]), .i_highest_common_mode(pv[13:10]), .i_phy_err(pv[14]),
    .i_host_drv_active(pv[15]), .i_low_power(pv[16]), .o_rsp_valid(valid), .o_rsp_byte(rbyte),
    .o_rsp_last(last), .o_rsp_type(rtype), .i_rsp_ready(ready));
  lcr_sink i_lcr_sink (.i_clk(i_clk), .i_rst(i_rst), .i_clr(clr), .i_slow(slow), .i_valid(valid),
    .i_byte(rbyte), .o_ready(ready), .o_data(sdat), .o_count(scnt));
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      $display("MISMATCH wb ack expected 1 seen timeout");
      num_errors++;
      results();
    end
    rd = q;
    cyc <= 1'b0;
    @(posedge i_clk);
  endtask
  // ----------------------------------------
  // wait for the sink to count n bytes, time out after 200 clocks
  // ----------------------------------------
  task automatic wait_bytes(input logic [4:0] n);
    int k;
    k = 0;
    while (scnt !== n && k < 200) begin
      @(posedge i_clk);
      k++;
    end
    if (k >= 200) begin
      $display("MISMATCH byte count expected %0d seen %0d", n, scnt);
      num_errors++;
      results();
    end
  endtask
  // ----------------------------------------
  // run one command and judge its response
  // ----------------------------------------
  task automatic run(input logic [16:0] p, input logic [1:0] c, input logic [9:0] s, input logic [7:0] ty,
    input logic [4:0] n, input logic [31:0] codes);
    pv <= p;
    wb(1'b1, 8'h08, {30'h0, c});
    wb(1'b1, 8'h04, {22'h0, s});
    clr <= 1'b1;
    repeat (6) @(posedge i_clk);
    clr <= 1'b0;
    wb(1'b1, 8'h00, {22'h3, ty});
    wait_bytes(n);
    chk("rsp type", {24'h0, ty | 8'h80}, {24'h0, rtype});
    chk("stream codes", codes, n == 5'd4 ? sdat[31:0] : sdat[127:96]);
    wb(1'b0, 8'h10, 32'h0);
    chk("codes reg", codes, rd);
  endtask
  localparam logic [16:0] SP[8] = '{17'h04000, 17'h08000, 17'h0, 17'h0, 17'h0, 17'h10000, 17'h0, 17'h08000};
  localparam logic [1:0] SC[8] = '{2'h1, 2'h1, 2'h3, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0};
  localparam logic [9:0] SS[8] = '{10'h001, 10'h001, 10'h204, 10'h206, 10'h108, 10'h009, 10'h207, 10'h001};
  localparam logic [31:0] SE[8] = '{32'h10006, 32'h10001, 32'h10002, 32'h10005, 32'h10003, 32'h10004, 32'h0,
    32'h10000};
  task automatic t_set_link();
    for (int i = 0; i < 8; i++) run(SP[i], SC[i], SS[i], 8'h09, 5'd4, SE[i]);
    $display("set link test done");
  endtask
  localparam logic [16:0] GP[7] = '{17'h1c07, 17'h1c17, 17'h1402, 17'h00e1, 17'h080f, 17'h2407, 17'h4000};
  localparam logic [7:0] GL[7] = '{8'h6f, 8'h61, 8'h20, 8'h07, 8'he5, 8'h61, 8'h00};
  task automatic t_get_link();
    for (int i = 0; i < 7; i++) begin
      slow <= (i == 4);
      run(GP[i], 2'h1, 10'h001, 8'h0a, 5'd16, i == 6 ? 32'h10006 : 32'h0);
      chk("status word", {24'h0, GL[i]}, sdat[95:64]);
      chk("other words", 32'h0, sdat[63:32] | sdat[31:0]);
      wb(1'b0, 8'h14, 32'h0);
      chk("status reg", {24'h0, GL[i]}, rd);
    end
    slow <= 1'b0;
    $display("get link test done");
  endtask
  task automatic t_regs_drop();
    wb(1'b0, 8'h08, 32'h0);
    chk("ctrl reset", 32'h1, rd);
    wb(1'b0, 8'h3c, 32'h0);
    chk("unmapped read", 32'h0, rd);
    clr <= 1'b1;
    wb(1'b1, 8'h00, 32'h0000_010a);
    clr <= 1'b0;
    repeat (8) @(posedge i_clk);
    chk("bytes after bad id", 32'h0, {27'h0, scnt});
    wb(1'b0, 8'h0c, 32'h0);
    chk("drop flag", 32'h2, rd & 32'h2);
    wb(1'b1, 8'h0c, 32'h2);
    wb(1'b0, 8'h0c, 32'h0);
    chk("drop cleared", 32'h0, rd & 32'h2);
    $display("register and drop test done");
  endtask
  task automatic t_busy();
    clr <= 1'b1;
    @(posedge i_clk);
    clr <= 1'b0;
    wb(1'b1, 8'h00, 32'h0000_030a);
    wb(1'b1, 8'h00, 32'h0000_0309);
    wb(1'b0, 8'h0c, 32'h0);
    chk("busy status", 32'h8a05, rd & 32'hff07);
    wait_bytes(5'd16);
    repeat (8) @(posedge i_clk);
    chk("bytes after refused", 32'h10, {27'h0, scnt});
    wb(1'b1, 8'h0c, 32'h4);
    wb(1'b0, 8'h0c, 32'h0);
    chk("refused cleared", 32'h8a00, rd & 32'hff07);
    $display("busy and refused test done");
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    t_regs_drop();
    t_set_link();
    t_get_link();
    t_busy();
    results();
  end
endmodule
